// >>> timecode_gpi_decoder.sv
// time code gpi decoder: relays, vitc window, panel menu, apb registers
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - immediate code closes matching relay output
// - deferred code loads countdown, fires at zero
// - expiry or second code fires output
// - byte one selects input, one bit each
// - vitc for sd, ancillary code for hd
// - delay view refreshes only on received gpi
// - 525 first line 10..32, default 10
// - 625 first line 6..32, default 6
// - 525 last line 10..32, default 20
// - 625 last line 6..32, default 21
// - first above last drags last up
// - sd codes accepted only inside window
// - up increments, down decrements numbers
// - list toggles step and apply live
// - push commits and returns to selection
// - inactivity timeout returns menu to idle
// - back item returns to parent or idle
module timecode_gpi_decoder import gpi_decoder_pkg::*; #(
    parameter int MENU_TIMEOUT = MENU_TIMEOUT_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_frame_strobe,
    input wire logic i_vitc_strobe,
    input wire logic [5:0] i_vitc_line,
    input wire logic i_atc_strobe,
    input wire logic [7:0] i_ub_select,
    input wire logic [7:0] i_ub_kind,
    input wire logic [7:0] i_ub_delay,
    input wire logic i_toggle_up,
    input wire logic i_toggle_down,
    input wire logic i_push,
    output logic [5:0] o_gpo,
    output logic [7:0] o_delay_view,
    output logic [6:0] o_menu_state,
    output logic [1:0] o_menu_item
);
    // ****************************************
    // panel pins
    // ****************************************
    logic [2:0] btn_rise; // push, down, up edges
    logic up, down, push, any_btn;

    pin_sync_edge #(.WIDTH(3)) u_buttons (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_pins({i_push, i_toggle_down, i_toggle_up}),
        .o_rise(btn_rise)
    );
    assign up = btn_rise[0];
    assign down = btn_rise[1];
    assign push = btn_rise[2];
    assign any_btn = |btn_rise;

    // ****************************************
    // settings state
    // ****************************************
    logic std625, next_std625;              // 625-line video
    logic hd_source, next_hd_source;        // take ancillary time code
    logic [5:0] window_first, next_first;   // first vitc search line
    logic [5:0] window_last, next_last;     // last vitc search line
    logic [5:0] line_min;                   // lowest legal line
    logic apb_write, apb_setup;
    menu_state_t state, next_state;
    logic [1:0] item, next_item;

    assign apb_write = i_psel && i_penable && i_pwrite;
    assign apb_setup = i_psel && !i_penable;
    assign line_min = std625 ? FIRST_MIN_625 : FIRST_MIN_525;

    // software writes, menu edits, then order repair
    always_comb begin
        next_std625 = std625;
        next_hd_source = hd_source;
        next_first = window_first;
        next_last = window_last;
        if (apb_write && i_paddr == REG_CTRL) begin
            next_hd_source = i_pwdata[CTRL_HD_BIT];
            if (i_pwdata[CTRL_STD_BIT] != std625) begin
                next_std625 = i_pwdata[CTRL_STD_BIT];
                next_first = next_std625 ? FIRST_MIN_625 : FIRST_MIN_525;
                next_last = next_std625 ? LAST_DEF_625 : LAST_DEF_525;
            end
        end else if (apb_write && i_paddr == REG_WINDOW) begin
            next_first = clamp_line(i_pwdata[WIN_FIRST_LSB +: 6], line_min);
            next_last = clamp_line(i_pwdata[WIN_LAST_LSB +: 6], line_min);
        end else if (state == MENU_EDIT_FIRST && (up || down)) begin
            next_first = clamp_line(up ? window_first + 6'h01 : window_first - 6'h01, line_min);
        end else if (state == MENU_EDIT_LAST && (up || down)) begin
            next_last = clamp_line(up ? window_last + 6'h01 : window_last - 6'h01, line_min);
        end else if (state == MENU_EDIT_STD && (up || down)) begin
            next_std625 = !std625;
            next_first = next_std625 ? FIRST_MIN_625 : FIRST_MIN_525;
            next_last = next_std625 ? LAST_DEF_625 : LAST_DEF_525;
        end
        if (next_first > next_last) begin
            next_last = next_first;
        end
    end

    // settings registers, 525-line defaults at reset
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            std625 <= 1'b0;
            hd_source <= 1'b0;
            window_first <= FIRST_MIN_525;
            window_last <= LAST_DEF_525;
        end else begin
            std625 <= next_std625;
            hd_source <= next_hd_source;
            window_first <= next_first;
            window_last <= next_last;
        end
    end

    // ****************************************
    // code intake
    // ****************************************
    logic in_window, code_take, imm_code, def_code, mark_code;
    logic [5:0] code_bits, fire, busy;

    assign in_window = (i_vitc_line >= window_first) && (i_vitc_line <= window_last);
    // sd reads vitc inside the window, hd reads ancillary code
    assign code_take = hd_source ? i_atc_strobe : (i_vitc_strobe && in_window);
    assign code_bits = code_take ? gpi_bits(i_ub_select) : 6'h00;
    assign imm_code = code_take && i_ub_kind == KIND_IMMEDIATE;
    assign def_code = code_take && i_ub_kind == KIND_DEFER;
    assign mark_code = code_take && i_ub_kind == KIND_MARK;

    // one countdown per relay
    for (genvar g = 0; g < GPI_COUNT; g++) begin : g_count
        gpi_countdown u_count (
            .i_clock(i_clock),
            .i_arst_n(i_arst_n),
            .i_load(def_code && code_bits[g]),
            .i_mark(mark_code && code_bits[g]),
            .i_tick(i_frame_strobe),
            .i_delay(i_ub_delay),
            .o_fire(fire[g]),
            .o_busy(busy[g])
        );
    end

    // ****************************************
    // relay outputs and delay view
    // ****************************************
    logic [5:0] imm_seen, next_imm_seen;   // codes seen this frame
    logic [5:0] imm_out, next_imm_out;     // immediate closures
    logic [5:0] def_out, next_def_out;     // deferred closures, one frame
    logic [5:0] next_gpo;
    logic [7:0] next_delay_view;

    // close at once, release at a frame with no code
    always_comb begin
        next_imm_seen = imm_seen;
        next_imm_out = imm_out;
        next_def_out = def_out;
        next_delay_view = o_delay_view;
        if (i_frame_strobe) begin
            next_imm_out = imm_seen;
            next_imm_seen = 6'h00;
            next_def_out = 6'h00;
        end
        if (imm_code) begin
            next_imm_seen = next_imm_seen | code_bits;
            next_imm_out = next_imm_out | code_bits;
        end
        next_def_out = next_def_out | fire;
        if (def_code && code_bits != 6'h00) begin
            next_delay_view = i_ub_delay;
        end
        next_gpo = next_imm_out | next_def_out;
    end

    // output registers
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            imm_seen <= 6'h00;
            imm_out <= 6'h00;
            def_out <= 6'h00;
            o_gpo <= 6'h00;
            o_delay_view <= 8'h00;
        end else begin
            imm_seen <= next_imm_seen;
            imm_out <= next_imm_out;
            def_out <= next_def_out;
            o_gpo <= next_gpo;
            o_delay_view <= next_delay_view;
        end
    end

    // ****************************************
    // panel menu
    // ****************************************
    logic [31:0] quiet_cnt, next_quiet_cnt; // cycles without a button
    logic timeout;

    assign timeout = quiet_cnt >= 32'(MENU_TIMEOUT - 1);

    // walk the menu tree
    always_comb begin
        next_state = state;
        next_item = item;
        next_quiet_cnt = (state == MENU_IDLE || any_btn) ? 32'h0 : quiet_cnt + 32'h1;
        unique case (state)
            MENU_IDLE: begin
                if (push) begin
                    next_state = MENU_TOP;
                    next_item = 2'h0;
                end
            end
            MENU_TOP: begin
                if (push) begin
                    unique case (item)
                        2'h0: next_state = MENU_VIEW;
                        2'h1: begin
                            next_state = MENU_WIN;
                            next_item = 2'h0;
                        end
                        2'h2: next_state = MENU_EDIT_STD;
                        TOP_BACK: next_state = MENU_IDLE;
                    endcase
                end else if (up) begin
                    next_item = item + 2'h1;
                end else if (down) begin
                    next_item = item - 2'h1;
                end
            end
            MENU_VIEW, MENU_EDIT_STD: begin
                if (push) begin
                    next_state = MENU_TOP;
                end
            end
            MENU_WIN: begin
                if (push) begin
                    if (item == 2'h0) begin
                        next_state = MENU_EDIT_FIRST;
                    end else if (item == 2'h1) begin
                        next_state = MENU_EDIT_LAST;
                    end else begin
                        next_state = MENU_TOP;
                        next_item = 2'h1;
                    end
                end else if (up) begin
                    next_item = (item == WIN_BACK) ? 2'h0 : item + 2'h1;
                end else if (down) begin
                    next_item = (item == 2'h0) ? WIN_BACK : item - 2'h1;
                end
            end
            MENU_EDIT_FIRST, MENU_EDIT_LAST: begin
                if (push) begin
                    next_state = MENU_WIN;
                end
            end
            default: begin
                next_state = MENU_IDLE;
            end
        endcase
        if (state != MENU_IDLE && !any_btn && timeout) begin
            next_state = MENU_IDLE;
            next_quiet_cnt = 32'h0;
        end
    end

    // menu registers
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= MENU_IDLE;
            item <= 2'h0;
            quiet_cnt <= 32'h0;
        end else begin
            state <= next_state;
            item <= next_item;
            quiet_cnt <= next_quiet_cnt;
        end
    end

    assign o_menu_state = state;
    assign o_menu_item = item;

    // ****************************************
    // apb slave
    // ****************************************
    logic [31:0] next_prdata;
    logic mapped;

    assign mapped = i_paddr == REG_CTRL || i_paddr == REG_WINDOW || i_paddr == REG_STATUS;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    // read data captured in the setup cycle
    always_comb begin
        next_prdata = o_prdata;
        if (apb_setup && !i_pwrite) begin
            next_prdata = 32'h0;
            if (i_paddr == REG_CTRL) begin
                next_prdata[CTRL_STD_BIT] = std625;
                next_prdata[CTRL_HD_BIT] = hd_source;
            end else if (i_paddr == REG_WINDOW) begin
                next_prdata[WIN_FIRST_LSB +: 6] = window_first;
                next_prdata[WIN_LAST_LSB +: 6] = window_last;
            end else if (i_paddr == REG_STATUS) begin
                next_prdata[STAT_GPO_LSB +: 6] = o_gpo;
                next_prdata[STAT_DELAY_LSB +: 8] = o_delay_view;
                next_prdata[STAT_MENU_LSB +: 7] = state;
            end
        end
    end

    // read data register
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= 32'h0;
        end else begin
            o_prdata <= next_prdata;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_IMM_CLOSE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (imm_code && code_bits != 6'h00) |=> ((o_gpo & $past(code_bits)) == $past(code_bits)))
        else $error("immediate code did not close its relay");
    AST_IMM_RELEASE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_frame_strobe && imm_seen == 6'h00 && !imm_code && fire == 6'h00) |=> o_gpo == 6'h00)
        else $error("relay held after a frame without code");
    AST_DEF_OUT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (fire != 6'h00) |=> ((o_gpo & $past(fire)) == $past(fire)))
        else $error("fired countdown did not close relay");
    AST_DELAY_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !def_code |=> $stable(o_delay_view))
        else $error("delay view changed without a received gpi");
    AST_SD_WINDOW: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (!hd_source && (i_vitc_line < window_first || i_vitc_line > window_last)) |-> !code_take)
        else $error("vitc outside window was accepted");
    AST_WINDOW_ORDER: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        window_first <= window_last)
        else $error("first line above last line");
    AST_FIRST_RANGE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        window_first >= line_min && window_last <= LINE_MAX)
        else $error("search line out of range");
    AST_STD_DEFAULT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (state == MENU_EDIT_STD && up && !std625) |=> (window_first == FIRST_MIN_625 && window_last == LAST_DEF_625))
        else $error("625 defaults not loaded");
    AST_BACK_TOP: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (state == MENU_TOP && item == TOP_BACK && push) |=> state == MENU_IDLE)
        else $error("back on main menu did not return to idle");
    AST_PUSH_COMMIT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ((state == MENU_EDIT_FIRST || state == MENU_EDIT_LAST) && push) |=> state == MENU_WIN)
        else $error("push did not return to selection");
    AST_MENU_TIMEOUT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        quiet_cnt < 32'(MENU_TIMEOUT))
        else $error("menu stayed past the timeout");
endmodule : timecode_gpi_decoder
`default_nettype wire

// >>> gpi_decoder_pkg.sv
// shared constants, types and helpers of the time code gpi decoder
`default_nettype none
package gpi_decoder_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLOCK_KHZ = 100000;          // 100 MHz core clock
    localparam int MENU_TIMEOUT_MS = 4000;      // menu inactivity limit in ms
    localparam int MENU_TIMEOUT_CYCLES = MENU_TIMEOUT_MS * CLOCK_KHZ;

    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;    // line standard and source select
    localparam logic [7:0] REG_WINDOW = 8'h04;  // vitc search window
    localparam logic [7:0] REG_STATUS = 8'h08;  // outputs, delay view, menu state
    localparam int CTRL_STD_BIT = 0;            // 1 selects 625-line video
    localparam int CTRL_HD_BIT = 1;             // 1 takes ancillary time code
    localparam int WIN_FIRST_LSB = 0;
    localparam int WIN_LAST_LSB = 8;
    localparam int STAT_GPO_LSB = 0;
    localparam int STAT_DELAY_LSB = 8;
    localparam int STAT_MENU_LSB = 16;

    // ****************************************
    // vitc line limits and reset values
    // ****************************************
    localparam logic [5:0] LINE_MAX = 6'h20;        // line 32
    localparam logic [5:0] FIRST_MIN_525 = 6'h0A;   // line 10
    localparam logic [5:0] FIRST_MIN_625 = 6'h06;   // line 6
    localparam logic [5:0] LAST_DEF_525 = 6'h14;    // line 20
    localparam logic [5:0] LAST_DEF_625 = 6'h15;    // line 21

    // ****************************************
    // user bit codes
    // ****************************************
    localparam logic [7:0] KIND_IMMEDIATE = 8'h00;  // held while input closed
    localparam logic [7:0] KIND_DEFER = 8'h01;      // starts countdown, carries delay
    localparam logic [7:0] KIND_MARK = 8'h02;       // sent at the delayed time
    localparam int GPI_COUNT = 6;
    localparam logic [1:0] TOP_BACK = 2'h3;         // back item of the main menu
    localparam logic [1:0] WIN_BACK = 2'h2;         // back item of the window menu

    // menu states, one-hot
    typedef enum logic [6:0] {
        MENU_IDLE = 7'h01,
        MENU_TOP = 7'h02,
        MENU_VIEW = 7'h04,
        MENU_WIN = 7'h08,
        MENU_EDIT_FIRST = 7'h10,
        MENU_EDIT_LAST = 7'h20,
        MENU_EDIT_STD = 7'h40
    } menu_state_t;

    // first data byte to one bit per input: 81,82,84,88,90,A0
    function automatic logic [5:0] gpi_bits(input logic [7:0] code);
        gpi_bits = (code[7:6] == 2'h2) ? code[5:0] : 6'h00;
    endfunction : gpi_bits

    // hold a line number inside lo..32
    function automatic logic [5:0] clamp_line(input logic [5:0] v, input logic [5:0] lo);
        if (v < lo) begin
            clamp_line = lo;
        end else if (v > LINE_MAX) begin
            clamp_line = LINE_MAX;
        end else begin
            clamp_line = v;
        end
    endfunction : clamp_line

endpackage : gpi_decoder_pkg
`default_nettype wire

// >>> pin_sync_edge.sv
// two-flop synchroniser with rising edge detect for panel pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync_edge import gpi_decoder_pkg::*; #(
    parameter int WIDTH = 3
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] meta, next_meta;      // first stage, read only by stable
    logic [WIDTH-1:0] stable, next_stable;  // second stage
    logic [WIDTH-1:0] prior, next_prior;    // edge history

    // next values of the chain
    always_comb begin
        next_meta = i_pins;
        next_stable = meta;
        next_prior = stable;
    end

    // chain registers
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta <= '0;
            stable <= '0;
            prior <= '0;
        end else begin
            meta <= next_meta;
            stable <= next_stable;
            prior <= next_prior;
        end
    end

    assign o_rise = stable & ~prior;
endmodule : pin_sync_edge
`default_nettype wire

// >>> gpi_countdown.sv
// per-input frame countdown for deferred codes
`timescale 1ns/100ps
`default_nettype none
module gpi_countdown import gpi_decoder_pkg::*; (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_load,
    input wire logic i_mark,
    input wire logic i_tick,
    input wire logic [7:0] i_delay,
    output logic o_fire,
    output logic o_busy
);
    logic [7:0] count, next_count;  // frames left
    logic busy, next_busy;          // countdown running

    // load, count down per frame, stop on expiry or mark
    always_comb begin
        next_count = count;
        next_busy = busy;
        if (i_load) begin
            next_count = i_delay;
            next_busy = 1'b1;
        end else if (i_tick && busy) begin
            if (count == 8'h00) begin
                next_busy = 1'b0;
            end else begin
                next_count = count - 8'h01;
            end
        end
        if (i_mark) begin
            next_busy = 1'b0;
        end
    end

    // countdown registers
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= 8'h00;
            busy <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
        end
    end

    // the expiry or the mark code fires; a mark fires even with no countdown running
    assign o_fire = (i_tick && busy && count == 8'h00 && !i_load) || i_mark;
    assign o_busy = busy;

    AST_ZERO_FIRE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_load && i_delay == 8'h00 && !i_tick && !i_mark ##1 i_tick && !i_load) |-> o_fire)
        else $error("countdown of zero did not fire at next frame");
    AST_LOAD_QUIET: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_load && i_delay == 8'h03 && !i_mark ##1 !i_mark [*2]) |-> !o_fire [*2])
        else $error("output fired before countdown expired");
endmodule : gpi_countdown
`default_nettype wire

// >>> gpi_encoder_model.sv
// upstream encoder model that inserts gpi user bit codes into time code
`timescale 1ns/100ps
`default_nettype none
module gpi_encoder_model (
    input wire logic i_clock,
    output logic o_vitc_strobe,
    output logic o_atc_strobe,
    output logic [5:0] o_line,
    output logic [7:0] o_select,
    output logic [7:0] o_kind,
    output logic [7:0] o_delay
);
    // ****************************************
    // one code per call, data scrambled after the strobe
    // ****************************************
    initial begin
        {o_vitc_strobe, o_atc_strobe, o_line, o_select, o_kind, o_delay} = '0;
    end
    // inserts one code: immediate repeats, deferred start, delayed-time mark
    task send(input logic hd, input logic [5:0] line, input logic [7:0] sel, kind, dly);
        @(posedge i_clock);
        {o_vitc_strobe, o_atc_strobe, o_line, o_select, o_kind, o_delay} <= {!hd, hd, line, sel, kind, dly};
        @(posedge i_clock);
        {o_vitc_strobe, o_atc_strobe, o_select, o_kind, o_delay} <= {2'h0, ~sel, ~kind, ~dly};
    endtask : send
endmodule : gpi_encoder_model
`default_nettype wire

// >>> timecode_gpi_decoder_test.sv
// self-checking bench for the time code gpi decoder
`timescale 1ns/100ps
`default_nettype none
module timecode_gpi_decoder_test import gpi_decoder_pkg::*;;
    logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00, dview;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] btn = 3'h0; // push, down, up
    logic vs, as;
    logic [5:0] line, gpo;
    logic [7:0] sel, kind, dly;
    logic [6:0] mstate;
    logic [1:0] mitem;
    int error_cnt = 0, cmp_count = 0;
    always #5 clock = ~clock;
    timecode_gpi_decoder #(.MENU_TIMEOUT(50)) timecode_gpi_decoder_i (.i_clock(clock), .i_arst_n(arst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_frame_strobe(frame), .i_vitc_strobe(vs),
        .i_vitc_line(line), .i_atc_strobe(as), .i_ub_select(sel), .i_ub_kind(kind), .i_ub_delay(dly),
        .i_toggle_up(btn[0]), .i_toggle_down(btn[1]), .i_push(btn[2]), .o_gpo(gpo), .o_delay_view(dview),
        .o_menu_state(mstate), .o_menu_item(mitem));
    gpi_encoder_model gpi_encoder_model_i (.i_clock(clock), .o_vitc_strobe(vs), .o_atc_strobe(as),
        .o_line(line), .o_select(sel), .o_kind(kind), .o_delay(dly));
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, wd};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    // one frame strobe, outputs settled on return
    task tick();
        @(posedge clock);
        frame <= 1'b1;
        @(posedge clock);
        frame <= 1'b0;
        @(negedge clock);
    endtask : tick
    task press(input int b);
        @(posedge clock);
        btn[b] <= 1'b1;
        repeat (4) @(posedge clock);
        btn[b] <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask : press
    task complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // ****************************************
    // scenarios
    // ****************************************
    task test_immediate();
        for (int i = 0; i < GPI_COUNT; i++) begin
            gpi_encoder_model_i.send(1'b0, 6'h0C, 8'h80 | (8'h01 << i), KIND_IMMEDIATE, 8'h00);
            @(negedge clock);
            chk(gpo, 32'h1 << i);
            tick();
            chk(gpo, 32'h1 << i);
            tick();
            chk(gpo, 32'h0);
        end
        gpi_encoder_model_i.send(1'b0, 6'h0C, 8'h41, KIND_IMMEDIATE, 8'h00);
        @(negedge clock);
        chk(gpo, 32'h0);
    endtask : test_immediate
    task test_deferred();
        gpi_encoder_model_i.send(1'b0, 6'h0C, 8'h84, KIND_DEFER, 8'h03);
        tick();
        tick();
        tick();
        chk(gpo, 32'h0);
        chk(dview, 32'h3);
        tick();
        chk(gpo, 32'h04);
        tick();
        chk(gpo, 32'h0);
        gpi_encoder_model_i.send(1'b0, 6'h0C, 8'h88, KIND_MARK, 8'h07);
        @(negedge clock);
        chk(gpo, 32'h08);
        chk(dview, 32'h3);
        tick();
    endtask : test_deferred
    task test_menu();
        press(2);
        chk(mstate, MENU_TOP);
        press(0);
        chk(mitem, 32'h1);
        press(2);
        press(2);
        chk(mstate, MENU_EDIT_FIRST);
        press(0);
        apb(1'b0, REG_WINDOW, 32'h0);
        chk(rd, 32'h140B);
        press(1);
        press(1);
        apb(1'b0, REG_WINDOW, 32'h0);
        chk(rd, 32'h140A);
        press(2);
        chk(mstate, MENU_WIN);
        repeat (60) @(posedge clock);
        @(negedge clock);
        chk(mstate, MENU_IDLE);
        press(2);
        press(1);
        chk(mitem, TOP_BACK);
        press(2);
        chk(mstate, MENU_IDLE);
        press(2);
        press(0);
        press(0);
        press(2);
        chk(mstate, MENU_EDIT_STD);
        press(0);
        apb(1'b0, REG_WINDOW, 32'h0);
        chk(rd, 32'h1506);
        press(2);
    endtask : test_menu
    task test_window();
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b0, REG_WINDOW, 32'h0);
        chk(rd, 32'h1506);
        apb(1'b1, REG_WINDOW, 32'h151E);
        apb(1'b0, REG_WINDOW, 32'h0);
        chk(rd, 32'h1E1E);
        gpi_encoder_model_i.send(1'b0, 6'h1D, 8'h81, KIND_IMMEDIATE, 8'h00);
        @(negedge clock);
        chk(gpo, 32'h0);
        gpi_encoder_model_i.send(1'b0, 6'h1E, 8'h82, KIND_IMMEDIATE, 8'h00);
        @(negedge clock);
        chk(gpo, 32'h02);
        apb(1'b1, REG_CTRL, 32'h3);
        gpi_encoder_model_i.send(1'b1, 6'h00, 8'hA0, KIND_IMMEDIATE, 8'h00);
        gpi_encoder_model_i.send(1'b0, 6'h1E, 8'h90, KIND_IMMEDIATE, 8'h00);
        @(negedge clock);
        chk(gpo, 32'h22);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask : test_window
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, REG_WINDOW, 32'h0);
        chk(rd, 32'h140A);
        test_immediate();
        test_deferred();
        test_menu();
        test_window();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        complete_run();
    end
endmodule : timecode_gpi_decoder_test
`default_nettype wire
